// file: core/wdt_pkg.sv
// constants shared by the watchdog timer and its register slave
// assumes a 100 MHz aclk standing in for the cpu clock domain
package wdt_pkg;
    // clock rates
    localparam int WDT_CLK_MHZ = 100;
    localparam int WDT_CPU_MHZ = 8;
    // counter step period in microseconds, cycles derived from the rate
    localparam int WDT_TICK_TIME_US = 2000;
    localparam int WDT_TICK_CYCLES = WDT_TICK_TIME_US * WDT_CLK_MHZ;
    // reset phase length in cpu cycles, converted to aclk cycles rounding up
    localparam int WDT_PHASE_SHORT_CPU = 256;
    localparam int WDT_PHASE_LONG_CPU = 4096;
    localparam int WDT_PHASE_SHORT_CYCLES =
        (WDT_PHASE_SHORT_CPU * WDT_CLK_MHZ + WDT_CPU_MHZ - 1) / WDT_CPU_MHZ;
    localparam int WDT_PHASE_LONG_CYCLES =
        (WDT_PHASE_LONG_CPU * WDT_CLK_MHZ + WDT_CPU_MHZ - 1) / WDT_CPU_MHZ;
    // register map: printed offset is an index, byte address is four times it
    localparam int WDT_CTRL_INDEX = 32'h0000002E;
    localparam int WDT_CTRL_BYTE_ADDR = WDT_CTRL_INDEX * 4;
    // control register layout and values
    localparam int WDT_ACT_BIT = 7;
    localparam int WDT_TOP_BIT = 6;
    localparam logic [7:0] WDT_CTRL_RESET = 8'h7F;
    localparam logic [6:0] WDT_CNT_RESET = 7'h7F;
    localparam logic [6:0] WDT_CNT_EDGE = 7'h40;
    // axi responses
    localparam logic [1:0] WDT_RESP_OKAY = 2'h0;
    localparam logic [1:0] WDT_RESP_DECERR = 2'h3;
    // run or reset phase
    typedef enum logic {
        WDT_RUN = 1'b0,
        WDT_PHASE = 1'b1
    } wdt_mode_e;
endpackage

// file: core/wdt_reg_if.sv
// register strobe and read-back between the bus slave and the watchdog core
// assumes both ends on the same aclk
`timescale 1ns/100ps
interface wdt_reg_if;
    logic wr_en;
    logic [7:0] wr_data;
    logic [7:0] rd_data;
    modport slave (output wr_en, output wr_data, input rd_data);
    modport core (input wr_en, input wr_data, output rd_data);
endinterface

// file: core/wdt_axil_slave.sv
// axi4-lite slave holding the single watchdog control word
// assumes one outstanding write and one outstanding read from the master
`timescale 1ns/100ps
module wdt_axil_slave #(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // write address and data
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // read
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // core side
    wdt_reg_if.slave regs
);
    import wdt_pkg::*;

    typedef struct packed {
        logic aw_got;
        logic aw_hit;
        logic w_got;
        logic [7:0] wdata;
        logic wstrb0;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [7:0] rdata;
    } wdt_axil_s;

    wdt_axil_s s_r;
    wdt_axil_s s_nxt;
    logic do_wr;

    // address and data are taken in either order, nothing new until b drains
    assign awready = !s_r.aw_got && !s_r.bvalid;
    assign wready = !s_r.w_got && !s_r.bvalid;
    assign arready = !s_r.rvalid;
    assign do_wr = s_r.aw_got && s_r.w_got && !s_r.bvalid;
    assign bvalid = s_r.bvalid;
    assign bresp = s_r.bresp;
    assign rvalid = s_r.rvalid;
    assign rresp = s_r.rresp;
    assign rdata = {24'h000000, s_r.rdata};
    // only byte lane 0 carries the register
    assign regs.wr_en = do_wr && s_r.aw_hit && s_r.wstrb0;
    assign regs.wr_data = s_r.wdata;

    always_comb begin
        s_nxt = s_r;
        if (awvalid && awready) begin
            s_nxt.aw_got = 1'b1;
            s_nxt.aw_hit = (awaddr[ADDR_W-1:2] == (ADDR_W-2)'(WDT_CTRL_INDEX));
        end
        if (wvalid && wready) begin
            s_nxt.w_got = 1'b1;
            s_nxt.wdata = wdata[7:0];
            s_nxt.wstrb0 = wstrb[0];
        end
        if (do_wr) begin
            s_nxt.aw_got = 1'b0;
            s_nxt.w_got = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp = s_r.aw_hit ? WDT_RESP_OKAY : WDT_RESP_DECERR;
        end
        if (s_r.bvalid && bready) begin
            s_nxt.bvalid = 1'b0;
        end
        if (arvalid && arready) begin
            s_nxt.rvalid = 1'b1;
            if (araddr[ADDR_W-1:2] == (ADDR_W-2)'(WDT_CTRL_INDEX)) begin
                s_nxt.rdata = regs.rd_data;
                s_nxt.rresp = WDT_RESP_OKAY;
            end else begin
                s_nxt.rdata = 8'h00;
                s_nxt.rresp = WDT_RESP_DECERR;
            end
        end
        if (s_r.rvalid && rready) begin
            s_nxt.rvalid = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule

// file: core/wdt_watchdog_timer.sv
// watchdog timer: free-running 7-bit down-counter, sticky activation bit,
// reset request and reset phase timing, registers over axi4-lite
// assumes the option straps are static and halt_exec is a one-cycle pulse
`timescale 1ns/100ps

// Contract
// R1: software rewrites the control register often enough that the counter never hits the reset point.
// R2: the seven-bit counter decrements on every step whether or not the watchdog is enabled.
// R3: software should load C0h to FFh, with activation and top bit set and the low six bits as the delay.
// R4: the watchdog starts disabled after reset and once enabled only a reset disables it.
// R5: a write with the activation bit set and the top bit clear requests an immediate reset.
// R6: a halt while the watchdog is active requests a reset unless the no-reset-on-halt option is set.
// R7: at the step period the smallest load times out within one step and the largest within 64 steps.
// R8: the reset phase lasts 256 or 4096 cpu cycles on top of the timeout.
// R9: with the hardware watchdog option the watchdog is always active and the activation bit is ignored.
// R10: with the no-reset-on-halt option a halt gives no reset, and software should reload before halting.
// R11: writing zero never clears the activation bit, only a reset does.
// R12: when enabled a reset is requested as the counter steps from 40h to 3Fh.
// R13: bits 6:0 of the control register always read the current counter value.
// R14: the control register resets to 7Fh and sits at index 002Eh.
// R15: the counter steps once per prescaler period from the clock and only reset clears the prescaler.
// R16: every watchdog reset cause gives a one-cycle reset request pulse; the code gives none for causes arriving while the reset phase runs.
module wdt_watchdog_timer #(
    parameter int ADDR_W = 8,
    parameter int TICK_CYCLES = wdt_pkg::WDT_TICK_CYCLES,
    parameter int SHORT_PHASE_CYCLES = wdt_pkg::WDT_PHASE_SHORT_CYCLES,
    parameter int LONG_PHASE_CYCLES = wdt_pkg::WDT_PHASE_LONG_CYCLES,
    parameter int PRESC_W = 18,
    parameter int PHASE_W = 16
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address and data
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // option straps
    input wire logic hw_watchdog_option,
    input wire logic no_reset_on_halt_option,
    input wire logic long_reset_phase_option,
    // cpu halt handshake
    input wire logic halt_exec,
    output logic halt_ok,
    // reset and status
    output logic sys_reset_req,
    output logic reset_phase,
    output logic watchdog_active
);
    import wdt_pkg::*;

    typedef struct packed {
        logic [PRESC_W-1:0] presc;
        logic [6:0] cnt;
        logic active;
        wdt_mode_e mode;
        logic [PHASE_W-1:0] phase;
        logic req;
        logic halt_ok;
    } wdt_core_s;

    wdt_core_s s_r;
    wdt_core_s s_nxt;
    wdt_reg_if regs ();

    logic tick;
    logic active_eff;
    logic wr_active;
    logic trig_soft;
    logic trig_time;
    logic trig_halt;
    logic trig_any;

    wdt_axil_slave #(
        .ADDR_W(ADDR_W)
    ) u_bus (
        .aclk(aclk),
        .aresetn(aresetn),
        .awaddr(s_axi_awaddr),
        .awvalid(s_axi_awvalid),
        .awready(s_axi_awready),
        .wdata(s_axi_wdata),
        .wstrb(s_axi_wstrb),
        .wvalid(s_axi_wvalid),
        .wready(s_axi_wready),
        .bresp(s_axi_bresp),
        .bvalid(s_axi_bvalid),
        .bready(s_axi_bready),
        .araddr(s_axi_araddr),
        .arvalid(s_axi_arvalid),
        .arready(s_axi_arready),
        .rdata(s_axi_rdata),
        .rresp(s_axi_rresp),
        .rvalid(s_axi_rvalid),
        .rready(s_axi_rready),
        .regs(regs)
    );

    // prescaler is never cleared by a write, hence the one-step spread in timeout
    assign tick = (s_r.presc == PRESC_W'(TICK_CYCLES - 1)); // [R15] [R7]
    assign active_eff = s_r.active || hw_watchdog_option; // [R9]
    assign wr_active = active_eff || regs.wr_data[WDT_ACT_BIT];
    assign trig_soft = regs.wr_en && wr_active && !regs.wr_data[WDT_TOP_BIT]; // [R5]
    // a refresh in the same cycle as the fatal step wins
    assign trig_time = tick && !regs.wr_en && active_eff
        && (s_r.cnt == WDT_CNT_EDGE); // [R12]
    assign trig_halt = halt_exec && active_eff && !no_reset_on_halt_option; // [R6] [R10]
    assign trig_any = trig_soft || trig_time || trig_halt;

    // read-back shows the live counter and the effective activation
    assign regs.rd_data = {active_eff, s_r.cnt}; // [R13]
    assign sys_reset_req = s_r.req;
    assign reset_phase = (s_r.mode == WDT_PHASE);
    assign watchdog_active = active_eff;
    assign halt_ok = s_r.halt_ok;

    always_comb begin
        s_nxt = s_r;
        s_nxt.req = 1'b0;
        s_nxt.halt_ok = 1'b0;
        if (tick) begin
            s_nxt.presc = '0;
            s_nxt.cnt = s_r.cnt - 7'h01; // [R2]
        end else begin
            s_nxt.presc = s_r.presc + PRESC_W'(1); // [R15]
        end
        if (regs.wr_en) begin
            s_nxt.cnt = regs.wr_data[6:0];
            // sticky: a zero written here never clears it
            s_nxt.active = s_r.active || regs.wr_data[WDT_ACT_BIT]; // [R11] [R4]
        end
        // halt proceeds only when it does not turn into a reset
        s_nxt.halt_ok = halt_exec && !trig_halt; // [R10]
        unique case (s_r.mode)
            WDT_RUN: begin
                if (trig_any) begin
                    s_nxt.req = 1'b1; // [R16]
                    s_nxt.mode = WDT_PHASE;
                    s_nxt.phase = long_reset_phase_option
                        ? PHASE_W'(LONG_PHASE_CYCLES - 1)
                        : PHASE_W'(SHORT_PHASE_CYCLES - 1); // [R8]
                end
            end
            WDT_PHASE: begin
                // further causes are absorbed while the phase runs
                if (s_r.phase == '0) begin
                    s_nxt.mode = WDT_RUN;
                end else begin
                    s_nxt.phase = s_r.phase - PHASE_W'(1); // [R8]
                end
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r.presc <= '0;
            s_r.cnt <= WDT_CNT_RESET; // [R14]
            s_r.active <= WDT_CTRL_RESET[WDT_ACT_BIT]; // [R4] [R14]
            s_r.mode <= WDT_RUN;
            s_r.phase <= '0;
            s_r.req <= 1'b0;
            s_r.halt_ok <= 1'b0;
        end else begin
            s_r <= s_nxt;
        end
    end

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    a_reset_value: assert property ($past(!aresetn) |-> regs.rd_data == {hw_watchdog_option, 7'h7F}) // [R14]
        else $error("control register not 7Fh after reset");

    a_active_sticky: assert property (s_r.active |=> s_r.active) // [R4]
        else $error("activation bit cleared without reset");

    a_zero_keeps: assert property (regs.wr_en && !regs.wr_data[7] && s_r.active
        |=> s_r.active && regs.rd_data[6:0] == $past(regs.wr_data[6:0])) // [R11]
        else $error("writing zero changed the activation bit");

    a_count_step: assert property (tick && !regs.wr_en
        |=> s_r.cnt == $past(s_r.cnt) - 7'h01) // [R2]
        else $error("counter did not step on the prescaler tick");

    a_count_hold: assert property (!tick && !regs.wr_en |=> $stable(s_r.cnt)) // [R15]
        else $error("counter moved between ticks");

    a_readback_cnt: assert property (regs.wr_en && !tick
        |=> regs.rd_data[6:0] == $past(regs.wr_data[6:0])) // [R13]
        else $error("read-back differs from written counter");

    a_timeout_req: assert property (tick && !regs.wr_en && active_eff
        && s_r.cnt == 7'h40 && !reset_phase |=> sys_reset_req) // [R12]
        else $error("no reset on step from 40h to 3Fh");

    a_disabled_quiet: assert property (!active_eff && !regs.wr_en && !reset_phase
        |=> !sys_reset_req) // [R4]
        else $error("reset request while disabled");

    a_soft_reset: assert property (regs.wr_en && regs.wr_data[7] && !regs.wr_data[6]
        && !reset_phase |=> sys_reset_req ##1 reset_phase) // [R5]
        else $error("software reset not requested");

    a_halt_reset: assert property (halt_exec && active_eff && !no_reset_on_halt_option
        && !reset_phase |=> sys_reset_req && !halt_ok) // [R6]
        else $error("halt while active did not reset");

    a_halt_pass: assert property (halt_exec && no_reset_on_halt_option |=> halt_ok) // [R10]
        else $error("halt blocked with no-reset-on-halt option");

    a_hw_timeout: assert property (hw_watchdog_option && tick && !regs.wr_en
        && s_r.cnt == 7'h40 && !reset_phase |=> sys_reset_req) // [R9]
        else $error("hardware watchdog option did not time out");

    a_req_pulse: assert property (sys_reset_req |=> !sys_reset_req) // [R16]
        else $error("reset request longer than one cycle");

    a_phase_hold: assert property (sys_reset_req |-> reset_phase [*8]) // [R8]
        else $error("reset phase shorter than expected");

    a_phase_start: assert property ($rose(reset_phase) |-> sys_reset_req) // [R8]
        else $error("reset phase began without a request");

    a_tick_spacing: assert property (tick |=> !tick) // [R15]
        else $error("prescaler ticks back to back");

    // the request and the phase start together, so software sees both in one cycle
    a_phase_with_req: assert property (sys_reset_req // [R8]
        |-> reset_phase)
        else $error("request without reset phase");

    a_phase_no_req: assert property (reset_phase // [R16]
        |=> !sys_reset_req)
        else $error("new request during reset phase");

    a_soft_effective: assert property (regs.wr_en && active_eff // [R5]
        && !regs.wr_data[WDT_TOP_BIT] && !reset_phase |=> sys_reset_req)
        else $error("top bit cleared while active gave no reset");

    a_presc_wrap: assert property (tick // [R15]
        |=> s_r.presc == '0)
        else $error("prescaler did not wrap on tick");

    a_presc_count: assert property (!tick // [R15]
        |=> s_r.presc == $past(s_r.presc) + PRESC_W'(1))
        else $error("prescaler did not count");

    a_write_loads: assert property (regs.wr_en // [R13]
        |=> s_r.cnt == $past(regs.wr_data[6:0]))
        else $error("write did not load the counter");

    a_active_set: assert property (regs.wr_en && regs.wr_data[WDT_ACT_BIT] // [R11]
        |=> s_r.active)
        else $error("activation bit not set by write");

    a_stays_off: assert property (!s_r.active // [R4]
        && !(regs.wr_en && regs.wr_data[WDT_ACT_BIT]) |=> !s_r.active)
        else $error("watchdog enabled without a write");

    a_hw_soft_reset: assert property (hw_watchdog_option && regs.wr_en // [R9]
        && !regs.wr_data[WDT_TOP_BIT] && !reset_phase |=> sys_reset_req)
        else $error("hardware option ignored a software reset");

    a_halt_quiet: assert property (halt_exec && no_reset_on_halt_option // [R10]
        && !regs.wr_en && !tick |=> !sys_reset_req)
        else $error("halt reset with no-reset-on-halt option");

    a_phase_end: assert property (reset_phase && s_r.phase == '0 // [R8]
        |=> !reset_phase)
        else $error("reset phase did not end");

    a_phase_steps: assert property (reset_phase && s_r.phase != '0 // [R8]
        |=> s_r.phase == $past(s_r.phase) - PHASE_W'(1))
        else $error("reset phase counter did not step");

    a_phase_short: assert property (sys_reset_req && !$past(long_reset_phase_option) // [R8]
        |-> s_r.phase == PHASE_W'(SHORT_PHASE_CYCLES - 1))
        else $error("short reset phase loaded wrong");

    a_phase_long: assert property (sys_reset_req && $past(long_reset_phase_option) // [R8]
        |-> s_r.phase == PHASE_W'(LONG_PHASE_CYCLES - 1))
        else $error("long reset phase loaded wrong");

    a_halt_ok_cause: assert property (halt_ok // [R6]
        |-> $past(halt_exec))
        else $error("halt accepted without a halt");

    a_inactive_halt: assert property (halt_exec && !active_eff && !reset_phase // [R6]
        |=> halt_ok)
        else $error("halt refused while disabled");

    // wrap through zero keeps the free run going when nobody reloads
    a_count_wrap: assert property (tick && !regs.wr_en && s_r.cnt == 7'h00 // [R2]
        |=> s_r.cnt == 7'h7F)
        else $error("counter did not wrap");
endmodule

// file: bench/tb_top.sv
// self-checking bench for the watchdog timer over axi4-lite
// assumes shortened tick and reset phase parameters; no far-side model
`timescale 1ns/100ps
module tb_top;
    import wdt_pkg::*;
    localparam int T = 20;
    localparam int PS = 12;
    localparam int PL = 24;
    localparam logic [7:0] A = 8'(WDT_CTRL_BYTE_ADDR);
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, prev_req;
    logic hw, nohalt, longp, halt_exec, halt_ok, sys_reset_req, reset_phase, watchdog_active;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, r;
    int bad_count = 0, checks_done = 0, cyc = 0, req_n = 0, req_at = 0, ok_n = 0;
    int ph_cnt = 0, ph_len = 0, n, t0, lp;
    wdt_watchdog_timer #(.TICK_CYCLES(T), .SHORT_PHASE_CYCLES(PS), .LONG_PHASE_CYCLES(PL)) dut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .hw_watchdog_option(hw), .no_reset_on_halt_option(nohalt),
        .long_reset_phase_option(longp), .halt_exec(halt_exec), .halt_ok(halt_ok),
        .sys_reset_req(sys_reset_req), .reset_phase(reset_phase),
        .watchdog_active(watchdog_active)
    );
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
        end
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task give_up(input string m);
        bad_count++;
        $display("wrong value at %0t: %s never finished", $time, m);
        final_report();
    endtask
    // reset phase length follows the option strap sampled at the trigger
    function automatic int phase_exp(input int l);
        return (l != 0) ? PL : PS;
    endfunction
    // load 40h+k reaches the fatal step after k+1 ticks, first tick 1..T away
    function automatic logic in_win(input int dt, input int k);
        return (dt >= k * T - 3) && (dt <= (k + 1) * T + 3);
    endfunction
    // bus-style sampling: readiness is settled 1 ns after the edge it follows
    task axi_wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s,
                output logic [1:0] rs);
        logic aw_on, w_on, at, wt;
        int k;
        awaddr <= a;
        wdata <= v;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        aw_on = 1'b1;
        w_on = 1'b1;
        k = 0;
        while (aw_on || w_on) begin
            #1;
            at = aw_on && awready;
            wt = w_on && wready;
            @(posedge aclk);
            if (at) begin
                awvalid <= 1'b0;
                aw_on = 1'b0;
            end
            if (wt) begin
                wvalid <= 1'b0;
                w_on = 1'b0;
            end
            k++;
            if (k > 50) give_up("write request");
        end
        bready <= 1'b1;
        k = 0;
        do begin
            #1;
            at = bvalid;
            rs = bresp;
            @(posedge aclk);
            k++;
            if (k > 50) give_up("write response");
        end while (at !== 1'b1);
        bready <= 1'b0;
    endtask
    task axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
        logic on, at, dn;
        int k;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        on = 1'b1;
        dn = 1'b0;
        k = 0;
        while (dn !== 1'b1) begin
            #1;
            at = on && arready;
            dn = rvalid;
            v = rdata;
            rs = rresp;
            @(posedge aclk);
            if (at) begin
                arvalid <= 1'b0;
                on = 1'b0;
            end
            k++;
            if (k > 50) give_up("read");
        end
        // rready stays high between reads, so back-to-back calls never drive it twice at one edge
    endtask
    task wait_req(input int max);
        int k, s;
        s = req_n;
        k = 0;
        while (req_n == s && k < max) begin
            @(posedge aclk);
            #1;
            k++;
        end
        @(posedge aclk);
    endtask
    task do_reset(input logic h, input logic nh, input logic l);
        int k;
        k = 0;
        while (reset_phase !== 1'b0 && k < 100) begin
            @(posedge aclk);
            k++;
        end
        aresetn <= 1'b0;
        hw <= h;
        nohalt <= nh;
        longp <= l;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
    endtask
    task halt_pulse;
        halt_exec <= 1'b1;
        @(posedge aclk);
        halt_exec <= 1'b0;
        repeat (3) @(posedge aclk);
    endtask
    // edge samples see pre-edge values because the design updates by nba
    always @(posedge aclk) begin
        cyc++;
        if (sys_reset_req === 1'b1) begin
            req_n++;
            req_at = cyc;
            if (prev_req === 1'b1) chk(prev_req, 1'b0, "request longer than one cycle");
        end
        prev_req = sys_reset_req;
        if (halt_ok === 1'b1) ok_n++;
        if (reset_phase === 1'b1) begin
            ph_cnt++;
        end else if (ph_cnt != 0) begin
            ph_len = ph_cnt;
            ph_cnt = 0;
        end
    end
    initial begin
        repeat (100000) @(posedge aclk);
        give_up("whole run");
    end
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, hw, nohalt, longp} = '0;
        {halt_exec, awaddr, araddr, wdata, wstrb, prev_req} = '0;
        void'($urandom(32'hc954bf78));
        @(posedge aclk);
        do_reset(1'b0, 1'b0, 1'b0);
        axi_rd(A, d, r);
        chk(d, 32'h7F, "control after reset");
        chk(r, WDT_RESP_OKAY, "mapped read response");
        chk(watchdog_active, 1'b0, "active after reset");
        axi_rd(8'h10, d, r);
        chk(r, WDT_RESP_DECERR, "unmapped read");
        axi_wr(8'h10, 32'hC1, 4'hF, r);
        chk(r, WDT_RESP_DECERR, "unmapped write");
        axi_wr(A, 32'h80, 4'hE, r);
        chk(watchdog_active, 1'b0, "write without byte strobe");
        $display("test reset and map done");
        n = req_n;
        repeat (70 * T) @(posedge aclk);
        axi_rd(A, d, r);
        chk(d[7:6], 2'b00, "counter passed 40h while disabled");
        chk(req_n, n, "no request while disabled");
        axi_wr(A, 32'hFF, 4'h1, r);
        chk(r, WDT_RESP_OKAY, "mapped write response");
        axi_rd(A, d, r);
        chk(d === 32'hFF || d === 32'hFE, 1'b1, "read back of live counter");
        axi_wr(A, 32'h7F, 4'h1, r);
        chk(watchdog_active, 1'b1, "activation survives zero write");
        $display("test free run and activation done");
        n = req_n;
        repeat (10) begin
            axi_wr(A, 32'hC3, 4'h1, r);
            repeat (2 * T) @(posedge aclk);
        end
        chk(req_n, n, "reloads keep the watchdog quiet");
        $display("test reload done");
        for (int i = 0; i < 4; i++) begin
            n = (i == 0) ? 0 : (i == 1) ? 63 : int'($urandom % 64);
            lp = int'($urandom % 2);
            do_reset(1'b0, 1'b0, lp[0]);
            ph_len = 0;
            axi_wr(A, {24'h0, 2'b11, 6'(n)}, 4'h1, r);
            #1;
            t0 = cyc;
            wait_req(70 * T);
            chk(in_win(req_at - t0, n), 1'b1, "timeout distance");
            do_reset(1'b0, 1'b0, 1'b0);
            chk(ph_len, phase_exp(lp), "reset phase length");
        end
        $display("test timeout done");
        n = req_n;
        axi_wr(A, {24'h0, 2'b10, 6'($urandom)}, 4'h1, r);
        repeat (3) @(posedge aclk);
        chk(req_n, n + 1, "software reset");
        do_reset(1'b0, 1'b0, 1'b0);
        n = ok_n;
        halt_pulse();
        chk(ok_n, n + 1, "halt while disabled");
        axi_wr(A, 32'hFF, 4'h1, r);
        n = req_n;
        halt_pulse();
        chk(req_n, n + 1, "halt while active");
        do_reset(1'b0, 1'b1, 1'b0);
        axi_wr(A, 32'hFF, 4'h1, r);
        n = req_n;
        t0 = ok_n;
        halt_pulse();
        chk(req_n, n, "halt with no-reset option");
        chk(ok_n, t0 + 1, "halt accepted with option");
        $display("test halt done");
        do_reset(1'b1, 1'b0, 1'b0);
        chk(watchdog_active, 1'b1, "hardware watchdog active");
        axi_rd(A, d, r);
        chk(d, 32'hFF, "hardware watchdog read");
        n = req_n;
        wait_req(70 * T);
        chk(req_n, n + 1, "hardware watchdog timeout");
        $display("test hardware option done");
        do_reset(1'b0, 1'b0, 1'b0);
        final_report();
    end
endmodule
